// *** core/seq_pkg.sv ***
// constants shared by the motion program sequencer
package seq_pkg;
   localparam logic [7:0] OP_JUMP_ALWAYS      = 8'h16; // 22
   localparam logic [7:0] OP_CALL_SUBROUTINE  = 8'h17; // 23
   localparam logic [7:0] OP_RETURN_SUBROUTINE = 8'h18; // 24
   localparam logic [7:0] OP_WAIT             = 8'h1B; // 27
   localparam logic [7:0] OP_JUMP_CONDITIONAL = 8'h15; // 21
   localparam logic [7:0] OP_CLEAR_ERROR      = 8'h24; // 36
   localparam logic [7:0] WAIT_TICKS          = 8'h00;
   localparam logic [7:0] WAIT_TARGET         = 8'h01;
   localparam logic [7:0] WAIT_HOME_SWITCH    = 8'h02;
   localparam logic [7:0] WAIT_END_SWITCH     = 8'h03;
   localparam logic [7:0] WAIT_HOMING_DONE    = 8'h04;
   localparam logic [7:0] COND_TIMEOUT        = 8'h08;
   localparam logic [31:0] VALUE_FROM_ACCU    = 32'hFFFFFFFF;
   localparam int STACK_DEPTH   = 8;
   localparam int CLOCK_HZ      = 20000000;
   localparam int TICK_MS       = 10;
   localparam int TICK_CYCLES   = CLOCK_HZ / 1000 * TICK_MS;
   localparam logic [15:0] PC_RESET = 16'h0000;
endpackage

// *** core/return_stack.sv ***
// return-address stack memory with registered read data
`timescale 1ns/1ps
module return_stack #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 16
) (
   input  wire logic                     i_clock,
   input  wire logic                     i_rst_b,
   input  wire logic                     i_push,
   input  wire logic                     i_pop,
   input  wire logic [WIDTH-1:0]         i_data,
   output logic      [WIDTH-1:0]         o_top,
   output logic      [$clog2(DEPTH):0]   o_count
);
   logic [WIDTH-1:0] mem [DEPTH];
   wire do_push = i_push && (o_count != DEPTH[$clog2(DEPTH):0]);
   wire do_pop  = i_pop && (o_count != '0);
   wire [$clog2(DEPTH):0] next_count = do_push ? o_count + 1'b1 :
                                      do_pop ? o_count - 1'b1 : o_count;

   always_ff @(posedge i_clock) begin
      if (do_push)
         mem[o_count[$clog2(DEPTH)-1:0]] <= i_data;
   end

   // top copy kept in a register so a pop completes in one cycle
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_count <= '0;
         o_top   <= '0;
      end else begin
         o_count <= next_count;
         if (do_push)
            o_top <= i_data;
         else if (do_pop && o_count > 1)
            o_top <= mem[o_count[$clog2(DEPTH)-1:0] - 2'd2];
      end
   end
endmodule

// *** core/motion_program_sequencer.sv ***
// program-flow unit: jumps, subroutine stack, waits with tick timeout
// Operation
// - jump_always loads program counter from the value field
// - call_subroutine pushes the address after the call then jumps to given address
// - return stack holds at most eight entries
// - call with full stack is ignored; execution simply advances
// - return_subroutine pops saved pc and resumes after the call
// - return with empty stack is ignored and advances
// - these instructions only act while a stored program runs
// - wait holds pc at its own address until condition or timeout
// - wait type 0 delays value ticks, motor ignored
// - wait type 1 waits for target reached of selected motor
// - wait type 2 waits for home switch of selected motor
// - wait type 3 waits for either end switch of selected motor
// - wait type 4 waits for homing done of selected motor
// - types 1..4 use value as timeout; zero means no timeout
// - value of -1 takes tick count from the accumulator
// - timeout expiry sets sticky timeout_error_flag, cleared by clear-error
// - jump_conditional type 8 branches on timeout_error_flag
// - one tick is ten milliseconds
`timescale 1ns/1ps
module motion_program_sequencer #(
   parameter int AXES        = 3,
   parameter int PC_WIDTH    = 16,
   parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
   input  wire logic                i_clock,
   input  wire logic                i_rst_b,
   input  wire logic                i_run,
   input  wire logic                i_instr_valid,
   input  wire logic [7:0]          i_opcode,
   input  wire logic [7:0]          i_type,
   input  wire logic [7:0]          i_motor,
   input  wire logic [31:0]         i_value,
   input  wire logic [31:0]         i_accu,
   input  wire logic [AXES-1:0]     i_target_reached,
   input  wire logic [AXES-1:0]     i_home_switch,
   input  wire logic [AXES-1:0]     i_end_switch_left,
   input  wire logic [AXES-1:0]     i_end_switch_right,
   input  wire logic [AXES-1:0]     i_homing_done,
   output logic      [PC_WIDTH-1:0] o_pc,
   output logic                     o_step,
   output logic                     o_waiting,
   output logic                     o_timeout_error_flag,
   output logic [$clog2(seq_pkg::STACK_DEPTH):0] o_stack_count
);
   // the motor field is eight bits wide, so at most 255 axes can be selected safely
   if (AXES < 1 || AXES > 255 || PC_WIDTH < 4 || PC_WIDTH > 32 || TICK_CYCLES < 2) begin : g_bad
      $error("motion_program_sequencer: unsupported parameters");
   end

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ----------------------------------------
   // tick divider
   // ----------------------------------------
   logic [$clog2(TICK_CYCLES)-1:0] div;
   logic                           tick;
   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync) begin
         div  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (div == $clog2(TICK_CYCLES)'(TICK_CYCLES - 1));
         div  <= (div == $clog2(TICK_CYCLES)'(TICK_CYCLES - 1)) ? '0 : div + 1'b1;
      end
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT} state_t;
   state_t state;
   logic [31:0] wait_left;
   logic [7:0]  wait_type;
   logic [7:0]  wait_motor;
   logic        wait_timed;

   wire take = i_run && i_instr_valid && (state == ST_IDLE);
   wire is_jump   = take && i_opcode == seq_pkg::OP_JUMP_ALWAYS;
   wire is_call   = take && i_opcode == seq_pkg::OP_CALL_SUBROUTINE;
   wire is_ret    = take && i_opcode == seq_pkg::OP_RETURN_SUBROUTINE;
   wire is_wait   = take && i_opcode == seq_pkg::OP_WAIT;
   wire is_jc_to  = take && i_opcode == seq_pkg::OP_JUMP_CONDITIONAL
                    && i_type == seq_pkg::COND_TIMEOUT;
   wire is_clear  = take && i_opcode == seq_pkg::OP_CLEAR_ERROR;

   wire [31:0] wait_value = (i_value == seq_pkg::VALUE_FROM_ACCU) ? i_accu : i_value;
   wire [PC_WIDTH-1:0] pc_inc = o_pc + 1'b1;
   wire [PC_WIDTH-1:0] target = i_value[PC_WIDTH-1:0];
   wire [PC_WIDTH-1:0] stack_top;
   wire stack_full  = o_stack_count == ($clog2(seq_pkg::STACK_DEPTH)+1)'(seq_pkg::STACK_DEPTH);
   wire stack_empty = o_stack_count == '0;

   wire motor_ok = wait_motor < 8'(AXES);
   wire [$clog2(AXES+1)-1:0] sel = wait_motor[$clog2(AXES+1)-1:0];
   wire cond_met = motor_ok && (
         (wait_type == seq_pkg::WAIT_TARGET      && i_target_reached[sel]) ||
         (wait_type == seq_pkg::WAIT_HOME_SWITCH && i_home_switch[sel]) ||
         (wait_type == seq_pkg::WAIT_END_SWITCH  &&
          (i_end_switch_left[sel] || i_end_switch_right[sel])) ||
         (wait_type == seq_pkg::WAIT_HOMING_DONE && i_homing_done[sel]));
   wire ticks_done  = wait_type == seq_pkg::WAIT_TICKS && wait_left == 32'h0;
   wire timed_out   = wait_type != seq_pkg::WAIT_TICKS && wait_timed && wait_left == 32'h0;
   wire wait_end    = (state == ST_WAIT) && (ticks_done || cond_met || timed_out);
   wire set_timeout = (state == ST_WAIT) && timed_out && !cond_met;

   return_stack #(
      .DEPTH (seq_pkg::STACK_DEPTH),
      .WIDTH (PC_WIDTH)
   ) u_stack (
      .i_clock (i_clock),
      .i_rst_b (rst_sync),
      .i_push  (is_call && !stack_full),
      .i_pop   (is_ret && !stack_empty),
      .i_data  (pc_inc),
      .o_top   (stack_top),
      .o_count (o_stack_count)
   );

   wire [PC_WIDTH-1:0] next_pc =
      is_jump                    ? target :
      (is_call && !stack_full)   ? target :
      (is_ret && !stack_empty)   ? stack_top :
      (is_jc_to && o_timeout_error_flag) ? target :
      is_wait                    ? o_pc :
      take                       ? pc_inc :
      wait_end                   ? pc_inc : o_pc;

   // ----------------------------------------
   // program counter and wait control
   // ----------------------------------------
   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync) begin
         o_pc       <= seq_pkg::PC_RESET;
         o_step     <= 1'b0;
         state      <= ST_IDLE;
         wait_left  <= 32'h0;
         wait_type  <= 8'h00;
         wait_motor <= 8'h00;
         wait_timed <= 1'b0;
      end else begin
         o_pc   <= next_pc;
         o_step <= (take && !is_wait) || wait_end;
         case (state)
            ST_IDLE: begin
               if (is_wait) begin
                  state      <= ST_WAIT;
                  wait_left  <= wait_value;
                  wait_type  <= i_type;
                  wait_motor <= i_motor;
                  wait_timed <= wait_value != 32'h0;
               end
            end
            ST_WAIT: begin
               if (wait_end || !i_run)
                  state <= ST_IDLE;
               else if (tick && wait_left != 32'h0)
                  wait_left <= wait_left - 1'b1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // the flag is hardware-set, so a timeout in the clear cycle still wins
   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync)
         o_timeout_error_flag <= 1'b0;
      else if (set_timeout)
         o_timeout_error_flag <= 1'b1;
      else if (is_clear)
         o_timeout_error_flag <= 1'b0;
   end

   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync)
         o_waiting <= 1'b0;
      else
         o_waiting <= (is_wait) || (state == ST_WAIT && !wait_end && i_run);
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // cycles since the last tick, so the strobe spacing is checked for any divider
   logic [$clog2(TICK_CYCLES)-1:0] since_tick;
   logic                           tick_seen;
   always_ff @(posedge i_clock or negedge rst_sync) begin
      if (!rst_sync) begin
         since_tick <= '0;
         tick_seen  <= 1'b0;
      end else if (tick) begin
         since_tick <= '0;
         tick_seen  <= 1'b1;
      end else begin
         since_tick <= since_tick + 1'b1;
      end
   end

   a_jump_loads_pc: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_jump |=> o_pc == $past(target)) else $error("jump target not loaded");
   a_jump_steps: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_jump |=> o_step && !o_waiting)
      else $error("jump gave no step pulse");
   a_call_pushes: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_call && !stack_full |=> o_pc == $past(target)
      && o_stack_count == $past(o_stack_count) + 1)
      else $error("call did not push and jump");
   a_call_saves: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_call && !stack_full |=> stack_top == $past(pc_inc))
      else $error("call saved wrong address");
   a_stack_bound: assert property (@(posedge i_clock) disable iff (!rst_sync)
      o_stack_count <= 8) else $error("stack beyond eight");
   a_full_call_skips: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_call && stack_full |=> o_pc == $past(pc_inc) && stack_full)
      else $error("full call not ignored");
   a_return_pops: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_ret && !stack_empty |=> o_pc == $past(stack_top)) else $error("return wrong");
   a_return_count: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_ret && !stack_empty |=> o_stack_count == $past(o_stack_count) - 1)
      else $error("return did not pop");
   a_empty_return: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_ret && stack_empty |=> o_pc == $past(pc_inc) && stack_empty)
      else $error("empty return not ignored");
   a_run_gates: assert property (@(posedge i_clock) disable iff (!rst_sync)
      !i_run && state == ST_IDLE |=> $stable(o_pc) && !o_step)
      else $error("instruction taken while stopped");

   a_wait_enters: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_wait |=> state == ST_WAIT && o_waiting && o_pc == $past(o_pc))
      else $error("wait not entered");
   a_wait_holds: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && !wait_end |=> $stable(o_pc)) else $error("pc moved in wait");
   a_tick_wait_ends: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && ticks_done |=> o_pc == $past(pc_inc) && o_step && !o_waiting)
      else $error("tick wait did not end");
   a_target_ends: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && wait_type == seq_pkg::WAIT_TARGET && motor_ok
      && i_target_reached[sel] |=> o_pc == $past(pc_inc) && o_step)
      else $error("target wait did not end");
   a_home_ends: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && wait_type == seq_pkg::WAIT_HOME_SWITCH && motor_ok
      && i_home_switch[sel] |=> o_pc == $past(pc_inc) && o_step)
      else $error("home switch wait did not end");
   a_end_switch_ends: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && wait_type == seq_pkg::WAIT_END_SWITCH && motor_ok
      && (i_end_switch_left[sel] || i_end_switch_right[sel]) |=> o_pc == $past(pc_inc))
      else $error("end switch wait did not end");
   a_homing_ends: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && wait_type == seq_pkg::WAIT_HOMING_DONE && motor_ok
      && i_homing_done[sel] |=> o_pc == $past(pc_inc) && o_step)
      else $error("homing wait did not end");
   a_untimed_holds: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && wait_type != seq_pkg::WAIT_TICKS && !wait_timed && !cond_met
      && i_run |=> state == ST_WAIT && $stable(o_pc))
      else $error("untimed wait ended without event");
   a_literal_count: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_wait && i_value != seq_pkg::VALUE_FROM_ACCU |=> wait_left == $past(i_value)
      && wait_timed == ($past(i_value) != 32'h0))
      else $error("wait count not loaded");
   a_accu_source: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_wait && i_value == seq_pkg::VALUE_FROM_ACCU |=> wait_left == $past(i_accu))
      else $error("accumulator count not loaded");

   a_timeout_flag: assert property (@(posedge i_clock) disable iff (!rst_sync)
      set_timeout |=> o_timeout_error_flag ##1 o_timeout_error_flag || $past(is_clear))
      else $error("timeout flag not set");
   a_clear_flag: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_clear |=> !o_timeout_error_flag)
      else $error("clear did not reset flag");
   a_cond_jump: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_jc_to && o_timeout_error_flag |=> o_pc == $past(target))
      else $error("error branch not taken");
   a_cond_skip: assert property (@(posedge i_clock) disable iff (!rst_sync)
      is_jc_to && !o_timeout_error_flag |=> o_pc == $past(pc_inc))
      else $error("error branch taken without flag");
   a_tick_spacing: assert property (@(posedge i_clock) disable iff (!rst_sync)
      tick && tick_seen |-> since_tick == $clog2(TICK_CYCLES)'(TICK_CYCLES - 1))
      else $error("tick spacing wrong");
   a_tick_period: assert property (@(posedge i_clock) disable iff (!rst_sync)
      tick |=> !tick) else $error("tick wider than one cycle");
   a_count_step: assert property (@(posedge i_clock) disable iff (!rst_sync)
      state == ST_WAIT && !wait_end && i_run && tick && wait_left != 32'h0
      |=> wait_left == $past(wait_left) - 1)
      else $error("wait counter not stepped");

   // ----------------------------------------
   // cover points
   // ----------------------------------------
   c_call_return: cover property (@(posedge i_clock) disable iff (!rst_sync)
      is_call ##[1:50] is_ret);
   c_timeout: cover property (@(posedge i_clock) disable iff (!rst_sync) set_timeout);
   c_cond_met: cover property (@(posedge i_clock) disable iff (!rst_sync) wait_end && cond_met);
   c_full_call: cover property (@(posedge i_clock) disable iff (!rst_sync) is_call && stack_full);
   c_accu_wait: cover property (@(posedge i_clock) disable iff (!rst_sync)
      is_wait && i_value == seq_pkg::VALUE_FROM_ACCU);
endmodule

// *** dv/program_memory_model.sv ***
// program memory and fetch model standing in front of the sequencer
`timescale 1ns/1ps
module program_memory_model (
   input  wire logic        i_clock,
   input  wire logic        i_slow,
   input  wire logic [15:0] i_pc,
   output logic             o_instr_valid,
   output logic             o_end,
   output logic [7:0]       o_opcode,
   output logic [7:0]       o_type,
   output logic [7:0]       o_motor,
   output logic [31:0]      o_value
);
   logic [7:0]  op_mem [256];
   logic [7:0]  ty_mem [256];
   logic [7:0]  mo_mem [256];
   logic [31:0] val_mem [256];
   logic        loaded [256];
   logic [15:0] last_pc = 16'h0000;
   wire  logic  fresh = (i_pc != last_pc);

   always @(posedge i_clock) last_pc <= i_pc;

   // slow mode hides a new address for one cycle, as a memory with read latency would
   assign o_end         = !loaded[i_pc[7:0]];
   assign o_instr_valid = loaded[i_pc[7:0]] && !(i_slow && fresh);
   assign o_opcode      = op_mem[i_pc[7:0]];
   assign o_type        = ty_mem[i_pc[7:0]];
   assign o_motor       = mo_mem[i_pc[7:0]];
   assign o_value       = val_mem[i_pc[7:0]];

   task automatic put(input logic [15:0] a, input logic [7:0] op, input logic [7:0] ty,
                      input logic [7:0] mo, input logic [31:0] v);
      op_mem[a[7:0]] = op;
      ty_mem[a[7:0]] = ty;
      mo_mem[a[7:0]] = mo;
      val_mem[a[7:0]] = v;
      loaded[a[7:0]] = 1'b1;
   endtask

   // empty cells show a changing pattern so nothing stale can look like an instruction
   task automatic wipe();
      for (int i = 0; i < 256; i++) begin
         put(16'(i), 8'(i) ^ 8'hA5, 8'h5A, 8'hC3, {4{8'(i)}});
         loaded[i] = 1'b0;
      end
   endtask

   initial wipe();
endmodule

// *** dv/motion_program_sequencer_tb.sv ***
// self-checking bench for the motion program sequencer
`timescale 1ns/1ps
module motion_program_sequencer_tb;
   localparam int TICKS = 4;
   logic        i_clock = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_run   = 1'b0;
   logic        slow    = 1'b0;
   logic [31:0] i_accu  = 32'h00000000;
   logic [2:0]  axis [5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
   logic        valid, at_end, o_step, o_waiting, o_timeout_error_flag;
   logic [7:0]  opcode, kind, motor;
   logic [31:0] value;
   logic [15:0] o_pc;
   logic [3:0]  o_stack_count;
   int          errors = 0;
   int          compares = 0;
   int          steps, waited;

   always #25 i_clock = ~i_clock;

   program_memory_model mem (.i_clock(i_clock), .i_slow(slow), .i_pc(o_pc),
      .o_instr_valid(valid), .o_end(at_end), .o_opcode(opcode), .o_type(kind),
      .o_motor(motor), .o_value(value));

   motion_program_sequencer #(.AXES(3), .PC_WIDTH(16), .TICK_CYCLES(TICKS)) dut (
      .i_clock(i_clock), .i_rst_b(i_rst_b), .i_run(i_run), .i_instr_valid(valid),
      .i_opcode(opcode), .i_type(kind), .i_motor(motor), .i_value(value), .i_accu(i_accu),
      .i_target_reached(axis[0]), .i_home_switch(axis[1]), .i_end_switch_left(axis[2]),
      .i_end_switch_right(axis[3]), .i_homing_done(axis[4]), .o_pc(o_pc), .o_step(o_step),
      .o_waiting(o_waiting), .o_timeout_error_flag(o_timeout_error_flag),
      .o_stack_count(o_stack_count));

   task automatic tick();
      @(posedge i_clock);
      #5;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // runs until the program counter lands on an empty cell, counting pulses and wait cycles
   task automatic run_prog(input int limit);
      int n;
      n = 0;
      steps = 0;
      waited = 0;
      i_run = 1'b1;
      do begin
         tick();
         n++;
         steps += (o_step === 1'b1);
         waited += (o_waiting === 1'b1);
      end while ((!at_end || o_waiting) && n < limit);
      i_run = 1'b0;
      if (n >= limit) check("program halt", 1, 0);
   endtask

   task automatic s_jump();
      mem.put(16'h0000, seq_pkg::OP_JUMP_ALWAYS, 8'h00, 8'h00, 32'h00000040);
      repeat (3) tick();
      check("pc while stopped", 32'h0, o_pc);
      run_prog(20);
      check("pc after jump", 32'h40, o_pc);
      check("jump steps", 1, steps);
   endtask

   task automatic s_stack();
      mem.wipe();
      for (int i = 0; i < 8; i++) mem.put(16'(64 + 2 * i), seq_pkg::OP_CALL_SUBROUTINE,
         8'h00, 8'h00, 32'(66 + 2 * i));
      mem.put(16'h0050, seq_pkg::OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h00000060);
      run_prog(60);
      check("pc after full call", 32'h51, o_pc);
      check("stack depth full", 32'h8, o_stack_count);
      check("call steps", 9, steps);
      mem.wipe();
      slow = 1'b1;
      for (int i = 0; i < 9; i++) mem.put(16'(65 + 2 * i), seq_pkg::OP_RETURN_SUBROUTINE,
         8'h00, 8'h00, 32'h00000000);
      run_prog(80);
      slow = 1'b0;
      check("pc after returns", 32'h42, o_pc);
      check("stack depth empty", 32'h0, o_stack_count);
      check("return steps", 9, steps);
   endtask

   task automatic s_ticks();
      mem.wipe();
      i_accu = 32'h00000005;
      mem.put(16'h0042, seq_pkg::OP_WAIT, seq_pkg::WAIT_TICKS, 8'h07, 32'h00000003);
      mem.put(16'h0043, seq_pkg::OP_WAIT, seq_pkg::WAIT_TICKS, 8'h00, seq_pkg::VALUE_FROM_ACCU);
      run_prog(200);
      check("pc after tick waits", 32'h44, o_pc);
      check("tick wait steps", 2, steps);
      check("tick wait length", 1, waited >= 7*TICKS-4 && waited <= 8*TICKS+2);
      check("error after ticks", 0, o_timeout_error_flag);
   endtask

   task automatic s_events();
      logic [15:0] base;
      logic [7:0]  ty;
      for (int i = 0; i < 5; i++) begin
         mem.wipe();
         base = o_pc;
         ty = (i < 3) ? 8'(i + 1) : 8'(i);
         mem.put(base, seq_pkg::OP_WAIT, ty, 8'h01, 32'h00000000);
         axis[i] = 3'h5;
         i_run = 1'b1;
         repeat (12) tick();
         check("held while waiting", 32'(base), o_pc);
         check("waiting level", 1, o_waiting);
         axis[i] = 3'h2;
         run_prog(10);
         axis[i] = 3'h0;
         check("pc after event", 32'(base + 16'h1), o_pc);
         check("error after event", 0, o_timeout_error_flag);
      end
   endtask

   task automatic s_timeout();
      logic [15:0] base;
      mem.wipe();
      base = o_pc;
      mem.put(base, seq_pkg::OP_WAIT, seq_pkg::WAIT_TARGET, 8'h02, 32'h00000002);
      mem.put(base + 16'h1, seq_pkg::OP_JUMP_CONDITIONAL, seq_pkg::COND_TIMEOUT, 8'h00,
         32'h00000090);
      run_prog(100);
      check("timeout wait length", 1, waited >= TICKS && waited <= 2 * TICKS + 1);
      check("error set", 1, o_timeout_error_flag);
      check("pc after error branch", 32'h90, o_pc);
      mem.wipe();
      mem.put(16'h0090, seq_pkg::OP_CLEAR_ERROR, 8'h00, 8'h00, 32'h00000000);
      mem.put(16'h0091, seq_pkg::OP_JUMP_CONDITIONAL, seq_pkg::COND_TIMEOUT, 8'h00,
         32'h00000010);
      run_prog(20);
      check("error cleared", 0, o_timeout_error_flag);
      check("pc without branch", 32'h92, o_pc);
   endtask

   // a stopped run leaves a wait, and a reset while stopped after a call empties the stack
   task automatic s_recover();
      logic [15:0] base;
      mem.wipe();
      base = o_pc;
      mem.put(base, seq_pkg::OP_WAIT, seq_pkg::WAIT_TARGET, 8'h01, 32'h00000000);
      i_run = 1'b1;
      repeat (6) tick();
      check("waiting before stop", 1, o_waiting);
      i_run = 1'b0;
      repeat (2) tick();
      check("waiting after stop", 0, o_waiting);
      check("pc after stop", 32'(base), o_pc);
      mem.put(base, seq_pkg::OP_CALL_SUBROUTINE, 8'h00, 8'h00, 32'h00000020);
      run_prog(10);
      check("depth before reset", 1, o_stack_count);
      i_rst_b = 1'b0;
      tick();
      check("pc in reset", 0, o_pc);
      check("depth in reset", 0, o_stack_count);
      i_rst_b = 1'b1;
      repeat (3) tick();
      mem.put(16'h0000, seq_pkg::OP_RETURN_SUBROUTINE, 8'h00, 8'h00, 32'h00000000);
      run_prog(10);
      check("pc after reset return", 32'h1, o_pc);
      check("depth after reset", 0, o_stack_count);
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge i_clock);
      #5 i_rst_b = 1'b1;
      repeat (3) tick();
      s_jump();
      s_stack();
      s_ticks();
      s_events();
      s_timeout();
      s_recover();
      finish_test();
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #250000;
      errors++;
      finish_test();
   end
endmodule
